// ### shared/bmgc_pkg.sv
// constants for boot memory map and global control
`default_nettype none
package bmgc_pkg;
   localparam logic [15:0] BMGC_ROM_LO = 16'h0000;
   localparam logic [15:0] BMGC_ROM_HI = 16'h17FF;
   localparam logic [15:0] BMGC_ROM_ALIAS_LO = 16'h8000;
   localparam logic [15:0] BMGC_ROM_ALIAS_HI = 16'h97FF;
   localparam logic [15:0] BMGC_RAM_LO = 16'h0000;
   localparam logic [15:0] BMGC_RAM_HI = 16'h3FFF;
   localparam logic [15:0] BMGC_IO_LO = 16'hF800;
   localparam logic [15:0] BMGC_IO_HI = 16'hFFFF;
   localparam logic [15:0] BMGC_SHADOW_ADDR = 16'hFF90;
   localparam logic [15:0] BMGC_GLOBAL_ADDR = 16'hFF91;
   localparam int BMGC_ROM_AW = 13;
   localparam int BMGC_RAM_AW = 14;
   localparam int BMGC_MAP_BIT = 0;
   localparam int BMGC_RESET_OUT_POLARITY_BIT = 3;
   localparam int BMGC_CLOCK_OUT_DISABLE_BIT = 4;
   localparam int BMGC_CSEL_LSB = 5;
   localparam int BMGC_CORE_SEL_BIT = 7;
   localparam logic [7:0] BMGC_GLOBAL_RESET = 8'h08;
   localparam logic [7:0] BMGC_GLOBAL_WMASK = 8'hF8;
   // arbitrary neutral revision value
   localparam logic [3:0] BMGC_REVISION = 4'h1;
   localparam logic [1:0] BMGC_SIZE_CODE = 2'h2;
   localparam logic BMGC_CODE_IS_RAM = 1'b1;
   // core clock 20 MHz; dividers derived relative to that
   localparam int BMGC_CORE_CLK_HZ = 20_000_000;
   localparam int BMGC_DIV_W = 3;
endpackage : bmgc_pkg
`default_nettype wire

// ### design/bmgc_mem.sv
// single-port memory with registered read data
`default_nettype none
module bmgc_mem
   #(parameter int AW = 14,
     parameter int DW = 8)
   (
   input wire logic core_clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
   );
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge core_clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : bmgc_mem
`default_nettype wire

// ### design/bmgc_clkdiv.sv
// divide-by-2^n enable pulse generator for the clock output
`default_nettype none
module bmgc_clkdiv
   import bmgc_pkg::*;
   (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] sel,
   output logic tick
   );
   logic [BMGC_DIV_W-1:0] cnt_reg;

   // sel 0 toggles every cycle, each step halves the rate
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
         case (sel)
            2'h0: tick <= 1'b1;
            2'h1: tick <= (cnt_reg[0] == 1'b1);
            2'h2: tick <= (cnt_reg[1:0] == 2'h3);
            default: tick <= (cnt_reg[2:0] == 3'h7);
         endcase
      end
   end
endmodule : bmgc_clkdiv
`default_nettype wire

// ### design/bmgc_top.sv
// boot memory map, shadow configuration and global control
`default_nettype none

module bmgc_top
   import bmgc_pkg::*;
   (
   input wire logic core_clk,
   input wire logic reset_n,
   // code fetch port
   input wire logic code_rd,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_rdata,
   output logic code_hit,
   // data space port
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [15:0] data_addr,
   input wire logic [7:0] data_wdata,
   output logic [7:0] data_rdata,
   output logic data_hit,
   // window F800-FFFF handed to the peripheral area
   output logic io_sel,
   // attach request from the usb control register
   input wire logic usb_attach_bit,
   output logic usb_connect,
   // internal reset request to drive out
   input wire logic reset_req,
   output logic reset_output_pin,
   output logic clock_output_pin,
   output logic clock_out_enable,
   output logic core_fast_sel,
   output logic map_switch_bit,
   // boot rom load port (mask contents come in at build time)
   input wire logic rom_load_we,
   input wire logic [12:0] rom_load_addr,
   input wire logic [7:0] rom_load_data
   );

   // ****************************************************
   // register state
   // ****************************************************
   logic map_reg;
   logic [7:0] global_reg;
   logic [7:0] global_next;

   wire logic shadow_sel = (data_addr == BMGC_SHADOW_ADDR);
   wire logic global_sel = (data_addr == BMGC_GLOBAL_ADDR);

   // only a power-up or function reset clears the map switch
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         map_reg <= 1'b0;
      end
      else if (data_wr && shadow_sel && data_wdata[BMGC_MAP_BIT])
      begin
         map_reg <= 1'b1;
      end
   end

   always_comb
   begin
      global_next = (data_wdata & BMGC_GLOBAL_WMASK);
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         global_reg <= BMGC_GLOBAL_RESET;
      end
      else if (data_wr && global_sel)
      begin
         global_reg <= global_next;
      end
   end

   // ****************************************************
   // address decode
   // ****************************************************
   logic c_rom;
   logic c_ram;
   logic d_ram;
   logic d_io;
   logic [12:0] rom_a;
   logic [13:0] ram_a;
   logic ram_we;

   always_comb
   begin
      c_rom = 1'b0;
      c_ram = 1'b0;
      rom_a = code_addr[12:0] & 13'h1FFF;
      if (code_addr >= BMGC_ROM_ALIAS_LO && code_addr <= BMGC_ROM_ALIAS_HI)
      begin
         c_rom = 1'b1;
         rom_a = 13'(code_addr - BMGC_ROM_ALIAS_LO);
      end
      else if (!map_reg && code_addr <= BMGC_ROM_HI)
      begin
         c_rom = 1'b1;
      end
      else if (map_reg && code_addr <= BMGC_RAM_HI)
      begin
         c_ram = 1'b1;
      end
   end

   always_comb
   begin
      d_ram = 1'b0;
      d_io = 1'b0;
      if (data_addr >= BMGC_IO_LO)
      begin
         d_io = 1'b1;
      end
      else if (!map_reg && data_addr <= BMGC_RAM_HI)
      begin
         d_ram = 1'b1;
      end
   end

   // ram written only through data space in boot mode
   always_comb
   begin
      ram_we = data_wr && d_ram;
      if (c_ram || !d_ram)
      begin
         ram_a = code_addr[13:0];
      end
      else
      begin
         ram_a = data_addr[13:0];
      end
   end

   // ****************************************************
   // memories
   // ****************************************************
   logic [7:0] rom_q;
   logic [7:0] ram_q;

   bmgc_mem #(.AW(BMGC_ROM_AW), .DW(8)) u_rom (
      .core_clk(core_clk),
      .we(rom_load_we),
      .addr(rom_load_we ? rom_load_addr : rom_a),
      .wdata(rom_load_data),
      .rdata(rom_q)
   );

   bmgc_mem #(.AW(BMGC_RAM_AW), .DW(8)) u_ram (
      .core_clk(core_clk),
      .we(ram_we),
      .addr(ram_a),
      .wdata(data_wdata),
      .rdata(ram_q)
   );

   // ****************************************************
   // read return, two cycles after the request
   // ****************************************************
   logic c_rom_q;
   logic c_ram_q;
   logic d_ram_q;
   logic d_reg_q;
   logic [7:0] reg_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         c_rom_q <= 1'b0;
         c_ram_q <= 1'b0;
         d_ram_q <= 1'b0;
         d_reg_q <= 1'b0;
         reg_q <= 8'h00;
      end
      else
      begin
         c_rom_q <= code_rd && c_rom;
         c_ram_q <= code_rd && c_ram;
         d_ram_q <= data_rd && d_ram;
         d_reg_q <= data_rd && (shadow_sel || global_sel);
         if (shadow_sel)
         begin
            reg_q <= {BMGC_CODE_IS_RAM, BMGC_SIZE_CODE, BMGC_REVISION,
                      map_reg};
         end
         else
         begin
            reg_q <= global_reg;
         end
      end
   end

   // output registers; memory data goes through one more stage
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         code_rdata <= 8'h00;
         code_hit <= 1'b0;
      end
      else
      begin
         code_hit <= c_rom_q || c_ram_q;
         code_rdata <= c_rom_q ? rom_q : (c_ram_q ? ram_q : 8'h00);
      end
   end

   // unmapped reads return zero so stale ram data never leaks out
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         data_rdata <= 8'h00;
         data_hit <= 1'b0;
      end
      else
      begin
         data_hit <= d_ram_q || d_reg_q;
         data_rdata <= d_ram_q ? ram_q : (d_reg_q ? reg_q : 8'h00);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         io_sel <= 1'b0;
      end
      else
      begin
         io_sel <= (data_rd || data_wr) && d_io;
      end
   end

   // ****************************************************
   // pins
   // ****************************************************
   logic tick;

   bmgc_clkdiv u_div (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .sel(global_reg[BMGC_CSEL_LSB +: 2]),
      .tick(tick)
   );

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         clock_output_pin <= 1'b0;
         clock_out_enable <= 1'b0;
      end
      else
      begin
         // gated low when disabled so the pin never glitches mid-cycle
         if (global_reg[BMGC_CLOCK_OUT_DISABLE_BIT])
         begin
            clock_output_pin <= 1'b0;
         end
         else if (tick)
         begin
            clock_output_pin <= ~clock_output_pin;
         end
         clock_out_enable <= ~global_reg[BMGC_CLOCK_OUT_DISABLE_BIT];
      end
   end

   // polarity bit picks which level of the request drives the pin
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reset_output_pin <= 1'b1;
      end
      else
      begin
         reset_output_pin <= global_reg[BMGC_RESET_OUT_POLARITY_BIT] ? reset_req
                             : ~reset_req;
      end
   end

   // rate select only; the core clock itself is switched elsewhere
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_fast_sel <= 1'b0;
      end
      else
      begin
         core_fast_sel <= global_reg[BMGC_CORE_SEL_BIT];
      end
   end

   // attach ignored until the map is switched
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         usb_connect <= 1'b0;
      end
      else
      begin
         usb_connect <= usb_attach_bit && map_reg;
      end
   end

   // registered copy of the map switch for the outside world
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         map_switch_bit <= 1'b0;
      end
      else
      begin
         map_switch_bit <= map_reg;
      end
   end
endmodule : bmgc_top
`default_nettype wire

// ### bench/bmgc_top_chk.sv
// port checker for the memory map and control block
`default_nettype none
module bmgc_top_chk
   import bmgc_pkg::*;
   (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic code_rd,
   input wire logic [15:0] code_addr,
   input wire logic code_hit,
   input wire logic data_rd,
   input wire logic data_wr,
   input wire logic [15:0] data_addr,
   input wire logic [7:0] data_wdata,
   input wire logic [7:0] data_rdata,
   input wire logic data_hit,
   input wire logic io_sel,
   input wire logic map_switch_bit,
   input wire logic core_fast_sel
   );
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // properties
   // ****
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   property p_rom_boot;
      code_rd && !map_switch_bit && code_addr <= BMGC_ROM_HI |-> ##2 code_hit;
   endproperty
   a_rom_boot: assert property (p_rom_boot)
      else $error("boot rom fetch missed");
   property p_rom_alias;
      code_rd && code_addr inside {[16'h8000:16'h97FF]} |-> ##2 code_hit;
   endproperty
   a_rom_alias: assert property (p_rom_alias)
      else $error("rom alias fetch missed");
   property p_ram_data;
      data_rd && !map_switch_bit && data_addr <= BMGC_RAM_HI |-> ##2 data_hit;
   endproperty
   a_ram_data: assert property (p_ram_data)
      else $error("boot data ram read missed");
   property p_ram_code;
      code_rd && map_switch_bit && code_addr <= BMGC_RAM_HI |-> ##2 code_hit;
   endproperty
   a_ram_code: assert property (p_ram_code)
      else $error("code ram fetch missed");
   property p_io;
      (data_rd || data_wr) && data_addr >= BMGC_IO_LO |=> io_sel;
   endproperty
   a_io: assert property (p_io)
      else $error("io window not selected");
   property p_regs;
      data_rd && data_addr == BMGC_SHADOW_ADDR |-> ##2 data_hit &&
         data_rdata[7:1] == {BMGC_CODE_IS_RAM, BMGC_SIZE_CODE, BMGC_REVISION};
   endproperty
   a_regs: assert property (p_regs)
      else $error("shadow read wrong");
   property p_map_hold;
      map_switch_bit |=> map_switch_bit;
   endproperty
   a_map_hold: assert property (p_map_hold)
      else $error("map switch cleared");
   property p_core_sel;
      data_wr && data_addr == BMGC_GLOBAL_ADDR |->
         ##3 core_fast_sel == $past(data_wdata[7], 3);
   endproperty
   a_core_sel: assert property (p_core_sel)
      else $error("core rate select wrong");
endmodule : bmgc_top_chk
bind bmgc_top bmgc_top_chk i_bmgc_top_chk (.core_clk(core_clk),
   .reset_n(reset_n), .code_rd(code_rd), .code_addr(code_addr),
   .code_hit(code_hit), .data_rd(data_rd), .data_wr(data_wr),
   .data_addr(data_addr), .data_wdata(data_wdata), .data_rdata(data_rdata),
   .data_hit(data_hit), .io_sel(io_sel), .map_switch_bit(map_switch_bit),
   .core_fast_sel(core_fast_sel));
`default_nettype wire

// ### bench/bmgc_core_model.sv
// core-side model: usb attach register and boot rom image
`default_nettype none
module bmgc_core_model
   (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic attach_req,
   output logic usb_attach_bit,
   output logic rom_load_we,
   output logic [12:0] rom_load_addr,
   output logic [7:0] rom_load_data
   );
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
         usb_attach_bit <= 1'b0;
      else
         usb_attach_bit <= attach_req;
   // only three words loaded: enough to tell rom, alias and ram apart
   initial
   begin
      rom_load_we = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         @(negedge core_clk);
         rom_load_we = 1'b1;
         rom_load_addr = (i == 2) ? 13'h17FF : 13'(i);
         rom_load_data = rom_load_addr[7:0] ^ 8'h5A;
      end
      @(negedge core_clk);
      rom_load_we = 1'b0;
      rom_load_data = ~rom_load_data;
   end
endmodule : bmgc_core_model
`default_nettype wire

// ### bench/bmgc_top_bench.sv
// self-checking bench for the memory map and control block
`default_nettype none
module bmgc_top_bench
   import bmgc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset_n, code_rd, data_rd, data_wr, reset_req, attach_req;
   logic [15:0] code_addr, data_addr;
   logic [7:0] data_wdata;
   wire logic [7:0] code_rdata, data_rdata, rom_load_data;
   wire logic [12:0] rom_load_addr;
   wire logic code_hit, data_hit, io_sel, usb_connect, reset_output_pin;
   wire logic clock_output_pin, clock_out_enable, core_fast_sel;
   wire logic map_switch_bit, usb_attach_bit, rom_load_we;
   int bad_count, checked, n;
   logic p;
   wire logic [2:0] pin_lvl = {reset_output_pin, clock_out_enable,
      core_fast_sel};
   bmgc_top i_bmgc_top (.*);
   bmgc_core_model i_bmgc_core_model (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ****
   // tasks
   // ****
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checked++;
      if (g !== x)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   // k: 0 data read, 1 data write, 2 code fetch; starts at a falling edge
   task automatic acc(input logic [1:0] k, input logic [15:0] a,
      input logic [7:0] d, input logic h, input logic [7:0] e);
      logic got;
      logic [7:0] v;
      logic io;
      got = 1'b0;
      v = 8'h00;
      data_rd = k == 0;
      data_wr = k == 1;
      code_rd = k == 2;
      data_addr = a;
      code_addr = a;
      data_wdata = d;
      @(negedge core_clk);
      {data_rd, data_wr, code_rd} = 3'b000;
      io = io_sel;
      repeat (3)
      begin
         if (data_hit === 1'b1 || code_hit === 1'b1)
         begin
            got = 1'b1;
            v = (k == 2) ? code_rdata : data_rdata;
         end
         @(negedge core_clk);
      end
      chk({7'h00, io}, {7'h00, k != 2 && a >= BMGC_IO_LO});
      if (k != 1)
      begin
         chk({7'h00, got}, {7'h00, h});
         chk(v & {8{h}}, e);
      end
   endtask : acc
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // ****
   // tests
   // ****
   initial
   begin
      {reset_n, code_rd, data_rd, data_wr, reset_req, attach_req} = 6'h00;
      {code_addr, data_addr, data_wdata} = 40'h00;
      repeat (6) @(negedge core_clk);
      reset_n = 1'b1;
      acc(0, BMGC_SHADOW_ADDR, 0, 1, 8'hC2);
      acc(0, BMGC_GLOBAL_ADDR, 0, 1, 8'h08);
      $display("test reset done");
      acc(2, 16'h0000, 0, 1, 8'h5A);
      acc(2, 16'h8001, 0, 1, 8'h5B);
      acc(2, 16'h17FF, 0, 1, 8'hA5);
      acc(2, 16'h1800, 0, 0, 0);
      acc(1, 16'h0000, 8'h3C, 0, 0);
      acc(1, 16'h3FFF, 8'hC3, 0, 0);
      acc(0, 16'h0000, 0, 1, 8'h3C);
      acc(0, 16'h3FFF, 0, 1, 8'hC3);
      acc(0, 16'h4000, 0, 0, 0);
      attach_req = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(usb_connect, 0);
      $display("test boot done");
      acc(1, BMGC_SHADOW_ADDR, 8'hFF, 0, 0);
      acc(1, BMGC_SHADOW_ADDR, 8'h00, 0, 0);
      acc(0, BMGC_SHADOW_ADDR, 0, 1, 8'hC3);
      chk(usb_connect, 1);
      chk(map_switch_bit, 1);
      acc(2, 16'h0000, 0, 1, 8'h3C);
      acc(2, 16'h3FFF, 0, 1, 8'hC3);
      acc(2, 16'h8000, 0, 1, 8'h5A);
      acc(1, 16'h0000, 8'h77, 0, 0);
      acc(2, 16'h0000, 0, 1, 8'h3C);
      acc(0, 16'h0000, 0, 0, 0);
      $display("test switch done");
      acc(1, BMGC_GLOBAL_ADDR, 8'hFF, 0, 0);
      acc(0, BMGC_GLOBAL_ADDR, 0, 1, 8'hF8);
      reset_req = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({5'h00, pin_lvl}, 8'h05);
      // toggles in a 64-cycle window are exact for any start phase
      for (int s = 0; s < 4; s++)
      begin
         acc(1, BMGC_GLOBAL_ADDR, 8'(s << 5), 0, 0);
         n = 0;
         repeat (64)
         begin
            p = clock_output_pin;
            @(negedge core_clk);
            n += int'(p !== clock_output_pin);
         end
         chk(8'(n), 8'(64 >> s));
      end
      chk({5'h00, pin_lvl}, 8'h02);
      $display("test global done");
      reset_n = 1'b0;
      @(negedge core_clk);
      reset_n = 1'b1;
      chk({map_switch_bit, usb_connect}, 2'b00);
      acc(0, BMGC_SHADOW_ADDR, 0, 1, 8'hC2);
      acc(2, 16'h0000, 0, 1, 8'h5A);
      $display("test second reset done");
      wrap_up();
   end
endmodule : bmgc_top_bench
`default_nettype wire
